// ---- core/ir_codec_pkg.sv ----
/*
 Package for the infrared pulse codec: register map, control field layout,
 reset values and timing constants.
 Assumes nothing of its surroundings beyond a SystemVerilog compiler.
*/
package ir_codec_pkg;

   // ==========================================================================
   // Register map (byte addresses on the APB slave)
   localparam logic [7:0] CTRL_ADDR    = 8'h00;  // ir_serial_control
   localparam logic [7:0] STATUS_ADDR  = 8'h04;  // codec status, read only
   localparam logic [7:0] BAUDDIV_ADDR = 8'h08;  // oversample divider

   // ==========================================================================
   // Control register fields
   localparam int          ENABLE_BIT   = 7;
   localparam int          WSEL_HI      = 6;
   localparam int          WSEL_LO      = 4;
   localparam int          WSEL_W       = 3;
   localparam logic [7:0]  CTRL_RESET   = 8'h00;
   localparam logic [7:0]  CTRL_WMASK   = 8'hf0;  // Bits 3..0 have no function

   // ==========================================================================
   // Timing: one bit interval is 16 oversample ticks
   localparam int          TICKS_PER_BIT = 16;
   localparam int          TICK_W        = 4;
   localparam logic [2:0]  WSEL_DEFAULT  = 3'h0;  // Code 0 selects 3/16
   localparam logic [15:0] BAUDDIV_RESET = 16'h0043;

   // Pulse width in oversample ticks per select code (code 0 is 3/16)
   function automatic logic [TICK_W-1:0] pulse_ticks(input logic [WSEL_W-1:0] sel);
      logic [TICK_W-1:0] r;
      r = 4'h3;
      unique case (sel)
         3'h0: r = 4'h3;
         3'h1: r = 4'h1;
         3'h2: r = 4'h2;
         3'h3: r = 4'h4;
         3'h4: r = 4'h5;
         3'h5: r = 4'h6;
         3'h6: r = 4'h7;
         3'h7: r = 4'h8;
      endcase
      return r;
   endfunction

endpackage

// ---- core/ir_tick_divider.sv ----
/*
 Oversample tick generator: one-cycle enable pulse every (div+1) clocks.
 Assumes div is steady or that a glitch of one interval after a change is acceptable.
*/
`timescale 1ns/100ps
module ir_tick_divider #(
   parameter int DIV_W = 16
) (
   input  wire logic             core_clk,
   input  wire logic             rst_b,
   input  wire logic [DIV_W-1:0] div,
   output logic                  tick
);

   typedef struct packed {
      logic [DIV_W-1:0] cnt;
      logic             tick;
   } div_state_t;

   div_state_t state_q;
   div_state_t state_d;

   // ==========================================================================
   // Count down, pulse on wrap
   always_comb begin
      state_d      = state_q;
      state_d.tick = 1'b0;
      if (state_q.cnt == '0) begin
         state_d.cnt  = div;
         state_d.tick = 1'b1;
      end else begin
         state_d.cnt = state_q.cnt - 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   assign tick = state_q.tick;

endmodule

// ---- core/infrared_pulse_codec.sv ----
/*
 Infrared pulse codec between one serial channel and the infrared pins,
 with an APB register slave holding the control register.
 Assumes the serial transmitter bit stream (serTxd) is synchronous to core_clk
 and changes only at oversample tick boundaries of this block's divider;
 ir_receive_pin is asynchronous and is synchronised here.
*/
// What this block does
// - A zero serial bit sends one high pulse, 3/16 bit wide by default.
// - Pulse width comes from the three-bit select field, control bits 6 to 4.
// - Received infrared pulses become ordinary asynchronous serial frames for the receiver.
// - No polarity inversion; control bits 3 to 0 have no function.
// - Control bit 7 enables infrared mode and resets to zero.
`timescale 1ns/100ps
module infrared_pulse_codec
   import ir_codec_pkg::*;
#(
   parameter int DIV_W = 16
) (
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Serial channel side
   input  wire logic        serTxd,
   output logic             serRxd,
   output logic             irModeActive,
   // Infrared pins
   output logic             irTransmitPin,
   input  wire logic        irReceivePin
);

   typedef enum logic [1:0] {
      RX_IDLE = 2'b00,
      RX_LOW  = 2'b01
   } rx_state_t;

   typedef struct packed {
      logic [7:0]        ctrl;
      logic [DIV_W-1:0]  baudDiv;
      logic [31:0]       prdata;
      logic              pready;
      logic              pslverr;
      logic [1:0]        rxSync;
      logic              rxPrev;
      logic [TICK_W-1:0] txTick;
      logic              txBusy;
      logic              irTx;
      rx_state_t         rxState;
      logic [TICK_W-1:0] rxTick;
      logic              serRxd;
      logic              pulseSeen;
   } codec_state_t;

   codec_state_t state_q;
   codec_state_t state_d;
   logic         tick;

   // ==========================================================================
   // Oversample tick source, one enable pulse per sixteenth of a bit
   ir_tick_divider #(
      .DIV_W (DIV_W)
   ) u_div (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .div      (state_q.baudDiv),
      .tick     (tick)
   );

   logic              enable;
   logic [WSEL_W-1:0] wsel;
   logic [TICK_W-1:0] width;
   logic              rxIn;
   logic              rxRise;

   // Field decode; receive input used as it is, no inversion stage
   assign enable = state_q.ctrl[ENABLE_BIT];
   assign wsel   = state_q.ctrl[WSEL_HI:WSEL_LO];
   assign width  = pulse_ticks(wsel);
   assign rxIn   = state_q.rxSync[1];
   assign rxRise = rxIn & ~state_q.rxPrev;

   // ==========================================================================
   // Next-state logic: APB slave, encoder, decoder
   always_comb begin
      state_d         = state_q;
      state_d.pready  = 1'b0;
      state_d.pslverr = 1'b0;

      // Pin synchroniser; only stage 1 is looked at by logic
      state_d.rxSync = {state_q.rxSync[0], irReceivePin};
      state_d.rxPrev = rxIn;

      // APB: answer one cycle into the access phase
      if (psel && penable && !state_q.pready) begin
         state_d.pready = 1'b1;
         state_d.prdata = '0;
         unique case (paddr)
            CTRL_ADDR: begin
               if (pwrite) begin
                  // Bits 3..0 are not stored and read zero
                  state_d.ctrl = pwdata[7:0] & CTRL_WMASK;
               end else begin
                  state_d.prdata = {24'h000000, state_q.ctrl};
               end
            end
            STATUS_ADDR: begin
               if (pwrite) begin
                  state_d.pslverr = 1'b1;   // Read-only register
               end else begin
                  state_d.prdata = {28'h0000000, state_q.txBusy, state_q.irTx,
                                    state_q.serRxd, rxIn};
               end
            end
            BAUDDIV_ADDR: begin
               if (pwrite) begin
                  state_d.baudDiv = pwdata[DIV_W-1:0];
               end else begin
                  state_d.prdata = 32'(state_q.baudDiv);
               end
            end
            default: begin
               state_d.pslverr = 1'b1;
            end
         endcase
      end

      // Encoder: a pulse starts at the start of every zero bit
      if (!enable) begin
         state_d.irTx   = 1'b0;
         state_d.txBusy = 1'b0;
         state_d.txTick = '0;
      end else if (tick) begin
         if (!state_q.txBusy && !serTxd) begin
            state_d.txBusy = 1'b1;
            state_d.irTx   = 1'b1;              // Always high-going
            state_d.txTick = 4'h1;
         end else if (state_q.txBusy) begin
            // Pulse ends after width ticks; rest of the bit stays low
            if (state_q.txTick >= width) begin
               state_d.irTx = 1'b0;
            end
            if (state_q.txTick == TICK_W'(TICKS_PER_BIT - 1)) begin
               state_d.txBusy = 1'b0;
               state_d.txTick = '0;
            end else begin
               state_d.txTick = state_q.txTick + 1'b1;
            end
         end
      end

      // Decoder: a pulse yields one zero-level bit, else line idles high
      if (!enable) begin
         state_d.rxState = RX_IDLE;
         state_d.serRxd  = 1'b1;
         state_d.rxTick  = '0;
      end else begin
         unique case (state_q.rxState)
            RX_IDLE: begin
               state_d.serRxd = 1'b1;
               if (rxRise) begin
                  state_d.rxState = RX_LOW;
                  state_d.serRxd  = 1'b0;
                  state_d.rxTick  = '0;
               end
            end
            RX_LOW: begin
               // Hold zero one full bit interval, then look for the next pulse
               if (tick) begin
                  if (state_q.rxTick == TICK_W'(TICKS_PER_BIT - 1)) begin
                     state_d.rxState = RX_IDLE;
                     state_d.serRxd  = 1'b1;    // No pulse gives a one
                  end else begin
                     state_d.rxTick = state_q.rxTick + 1'b1;
                  end
               end
            end
            default: begin
               state_d.rxState = RX_IDLE;
            end
         endcase
      end
   end

   // ==========================================================================
   // State register; reset clears the enable bit and selects 3/16 width
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q         <= '0;
         state_q.ctrl    <= CTRL_RESET;
         state_q.baudDiv <= BAUDDIV_RESET[DIV_W-1:0];
         state_q.rxSync  <= 2'h0;
         state_q.serRxd  <= 1'b1;
         state_q.rxState <= RX_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // ==========================================================================
   // Outputs straight from flip-flops; serial line idles high when off
   assign prdata        = state_q.prdata;
   assign pready        = state_q.pready;
   assign pslverr       = state_q.pslverr;
   assign irTransmitPin = state_q.irTx;
   assign serRxd        = state_q.serRxd;
   assign irModeActive  = enable;

endmodule

// ---- sim/ir_transceiver_model.sv ----
/*
 Far-side infrared transceiver: sends one light pulse on request.
 Assumes the bench raises fire for one clock.
*/
`timescale 1ns/100ps
module ir_transceiver_model (
   input  wire logic core_clk,
   input  wire logic fire,
   output logic      irReceivePin
);
   // ==========================================
   // Pulse of six clocks; no light reads low
   int cnt = 0;
   always @(posedge core_clk) begin
      if (fire) begin
         cnt <= 6;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
      end
   end
   assign irReceivePin = (cnt > 0);
endmodule

// ---- sim/infrared_pulse_codec_props.sv ----
/*
 Checker for the infrared codec pins and register bus.
 Assumes it is bound to the codec top.
*/
`timescale 1ns/100ps
module infrared_pulse_codec_props (
   input logic        core_clk,
   input logic        rst_b,
   input logic        psel,
   input logic        penable,
   input logic        pwrite,
   input logic [7:0]  paddr,
   input logic [31:0] pwdata,
   input logic        pready,
   input logic        pslverr,
   input logic        serTxd,
   input logic        serRxd,
   input logic        irModeActive,
   input logic        irTransmitPin,
   input logic        irReceivePin
);
   import ir_codec_pkg::*;
   // ==========================================
   // Helpers
   // Shadow of the divider and length of the current transmit pulse; a pulse
   // lasts at most eight ticks, and a tick spans (div+1) clocks
   logic [15:0] divShadow;
   int          hiRun;
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         divShadow <= BAUDDIV_RESET;
         hiRun     <= 0;
      end else begin
         if (psel && penable && pready && pwrite && !pslverr && paddr == BAUDDIV_ADDR) begin
            divShadow <= pwdata[15:0];
         end
         hiRun <= irTransmitPin ? hiRun + 1 : 0;
      end
   end
   // ==========================================
   // Properties
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   AST_TX_OFF: assert property (!irModeActive [*2] |-> !irTransmitPin)
      else $error("tx pin high while off");
   AST_RX_OFF: assert property (!irModeActive [*2] |-> serRxd)
      else $error("rx bit low while off");
   AST_TX_RISE: assert property ($rose(irTransmitPin) |-> !$past(serTxd))
      else $error("pulse without zero bit");
   AST_TX_FALL: assert property (irTransmitPin |-> hiRun < 8 * (int'(divShadow) + 2))
      else $error("pulse too long");
   AST_RX_ZERO: assert property ($rose(irReceivePin) && serRxd && irModeActive |-> ##[2:5] !serRxd)
      else $error("no zero bit for pulse");
   AST_RX_HOLD: assert property ($fell(serRxd) |-> !serRxd [*8])
      else $error("zero bit too short");
   AST_MODE: assert property (pready && pwrite && !pslverr && paddr == 8'h00 |=> irModeActive == $past(pwdata[7]))
      else $error("enable not taken");
endmodule
bind infrared_pulse_codec infrared_pulse_codec_props i_infrared_pulse_codec_props (.core_clk, .rst_b, .psel,
   .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .serTxd, .serRxd, .irModeActive, .irTransmitPin,
   .irReceivePin);

// ---- sim/tb_infrared_pulse_codec.sv ----
/*
 Testbench for the infrared codec: registers, pulse widths, decoding.
 Assumes divider value 1, so one bit is 32 clocks.
*/
`timescale 1ns/100ps
module tb_infrared_pulse_codec;
   import ir_codec_pkg::*;
   logic core_clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, serTxd = 1, fire = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, serRxd, irModeActive, irTransmitPin, irReceivePin, er;
   int failures = 0, compares = 0, hi, lo;
   int wid[8] = '{3, 1, 2, 4, 5, 6, 7, 8};
   always #4 core_clk = ~core_clk;
   infrared_pulse_codec i_infrared_pulse_codec (.core_clk, .rst_b, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .serTxd, .serRxd, .irModeActive, .irTransmitPin, .irReceivePin);
   ir_transceiver_model i_ir_transceiver_model (.core_clk, .fire, .irReceivePin);
   // ==========================================
   // Shared tasks
   task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
      compares++;
      if (s !== x) begin
         failures++;
         $display("BAD %s exp %h seen %h", nm, x, s);
      end
   endtask
   // Waits on pready as long as it takes; only the watchdog ends a hung transfer
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge core_clk) penable <= 1;
      do begin @(posedge core_clk); end while (pready !== 1'b1);
      rd = prdata; er = pslverr;
      psel <= 0; penable <= 0;
      @(posedge core_clk);
   endtask
   task run(input logic tx, input int n);
      serTxd <= tx;
      repeat (n) begin @(posedge core_clk); hi += irTransmitPin; lo += !serRxd; end
   endtask
   // ==========================================
   // Scenarios
   task t_regs;
      apb(0, 8'h00, 0); chk("ctrl reset", rd, 32'h0);
      apb(0, 8'h08, 0); chk("div reset", rd, 32'h43);
      apb(0, 8'h04, 0); chk("status idle", rd, 32'h2);
      apb(1, 8'h04, 0); chk("status write", er, 1);
      apb(1, 8'h08, 1);
      // The divider takes a new value only at its next wrap, so let it pass
      repeat (int'(BAUDDIV_RESET) + 2) @(posedge core_clk);
      apb(1, 8'h00, 32'h7f); apb(0, 8'h00, 0); chk("ctrl low bits", rd, 32'h70);
      chk("mode off", irModeActive, 0);
      apb(0, 8'h0c, 0); chk("unmapped", er, 1);
      $display("regs done");
   endtask
   task t_tx;
      for (int c = 0; c < 8; c++) begin
         apb(1, 8'h00, 32'h80 | (c << 4)); hi = 0; lo = 0;
         run(0, 32); run(1, 40); chk("width", hi, 2 * wid[c]);
      end
      $display("tx done");
   endtask
   task t_rx_off;
      apb(1, 8'h00, 32'h80); hi = 0; lo = 0; fire <= 1;
      chk("mode on", irModeActive, 1);
      @(posedge core_clk) fire <= 0;
      run(1, 60); chk("rx zero", lo inside {[30:34]}, 1); chk("no echo", hi, 0);
      apb(1, 8'h00, 32'h0); hi = 0; lo = 0; fire <= 1;
      @(posedge core_clk) fire <= 0;
      run(0, 32); run(1, 40); chk("off", hi + lo, 0);
      $display("rx and off done");
   endtask
   // Mid-run reset must clear the enable bit and load the divider with 43 hex again
   task t_reset;
      apb(1, 8'h00, 32'hb0);
      rst_b <= 0;
      repeat (3) @(posedge core_clk);
      rst_b <= 1;
      @(posedge core_clk);
      chk("mode after reset", irModeActive, 0);
      chk("tx after reset", irTransmitPin, 0);
      apb(0, 8'h00, 0); chk("ctrl after reset", rd, 32'h0);
      apb(0, 8'h08, 0); chk("div after reset", rd, 32'h43);
      $display("reset done");
   endtask
   task close_out;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge core_clk);
      rst_b <= 1;
      @(posedge core_clk);
      t_regs; t_tx; t_rx_off; t_reset;
      close_out;
   end
   // Watchdog well above the expected run of about 900 clocks
   initial begin
      repeat (20000) @(posedge core_clk);
      failures++;
      close_out;
   end
endmodule
